// *** logic/matrix_ctl.sv ***
// Control logic of the matrix LED driver: mode, breathing gate, auto
// play sequencing, frame-end interrupt and both shutdown modes.
// Assumes a serial front end giving one-cycle requests on clk, and a
// frame-tick enable pulse from the frame timing divider.
//
// Function
// [RULE1] Breathing on frame switch only when enabled
// [RULE2] Auto play end: pin low, flag set together
// [RULE3] Pin released after at least 7 ms low
// [RULE4] Frame-end flag cleared only by reading it
// [RULE5] Host turns off unfitted LED positions
// [RULE6] Store up to eight individually addressed frames
// [RULE7] Host double-buffers long animations in fours
// [RULE8] Shutdown keeps every register value
// [RULE9] Soft sleep bit zero blanks whole matrix
// [RULE10] Soft shutdown still serves register access
// [RULE11] Shutdown pin low blanks the device
// [RULE12] Hardware shutdown refuses all register access
// [RULE13] Mode 01 plays frames in sequence
// [RULE14] Breath enable ignored in audio mode
// [RULE15] Pin release independent of flag
`timescale 1ns/100ps
module matrix_ctl #(
  parameter int IRQ_LOW = matrix_ctl_pkg::IRQ_LOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access
  input matrix_ctl_pkg::reg_req_t req,
  output matrix_ctl_pkg::reg_rsp_t rsp,
  // Pins
  input wire logic hw_sleep_n,
  output logic frame_end_irq_n_o,
  output logic frame_end_irq_n_oe,
  // Display engine
  input wire logic frame_tick,
  output logic [matrix_ctl_pkg::FRAME_IDX_W-1:0] frame_shown,
  output logic breath_active,
  output logic matrix_blank
);
  import matrix_ctl_pkg::*;

  logic sleep_s1_reg, sleep_s2_reg;
  logic [7:0] config_reg, config_next;
  logic [7:0] breath_two_reg, breath_two_next;
  logic [7:0] power_down_reg, power_down_next;
  logic flag_reg, flag_next;
  logic [FRAME_IDX_W-1:0] frame_reg, frame_next;
  logic playing_reg, playing_next;
  logic prev_auto_reg, prev_auto_next;
  reg_rsp_t rsp_reg, rsp_next;
  logic breath_reg, breath_next;
  logic blank_reg, blank_next;
  logic irq_oe_reg;
  logic end_evt, pin_low, hw_off, soft_sleep_ctl;
  play_mode_t mode;

  // Shutdown pin comes from outside: two-stage synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
    end else begin
      sleep_s1_reg <= hw_sleep_n;
      sleep_s2_reg <= sleep_s1_reg;
    end
  end

  assign hw_off = !sleep_s2_reg; // see [RULE11]
  assign mode = play_mode_t'(config_reg[MODE_LSB +: 2]);
  assign soft_sleep_ctl = power_down_reg[SOFT_SLEEP_BIT];

  // Register writes; shutdown never touches stored values
  always_comb begin
    config_next = config_reg; // see [RULE8]
    breath_two_next = breath_two_reg;
    power_down_next = power_down_reg;
    if (req.wr && !hw_off) begin // see [RULE10] see [RULE12]
      unique case (req.addr)
        CONFIG_OFS: config_next = req.wdata;
        BREATH_CONTROL_TWO_OFS: breath_two_next = req.wdata;
        POWER_DOWN_CONTROL_OFS: power_down_next = req.wdata;
        default: ;
      endcase
    end
  end

  // Reads answer one cycle later; none while the pin holds shutdown
  always_comb begin
    rsp_next = '0;
    if (req.rd && !hw_off) begin // see [RULE12]
      rsp_next.valid = 1'b1;
      unique case (req.addr)
        CONFIG_OFS: rsp_next.rdata = config_reg;
        FRAME_STATE_OFS: begin
          rsp_next.rdata = {3'h0, flag_reg, 1'b0, frame_reg};
        end
        BREATH_CONTROL_TWO_OFS: rsp_next.rdata = breath_two_reg;
        POWER_DOWN_CONTROL_OFS: rsp_next.rdata = power_down_reg;
        default: rsp_next.rdata = '0;
      endcase
    end
  end

  // Auto play sequencing over the eight-frame store
  always_comb begin
    frame_next = frame_reg;
    playing_next = playing_reg;
    prev_auto_next = (mode == MODE_AUTO_PLAY);
    end_evt = 1'b0;
    if (mode == MODE_AUTO_PLAY && !prev_auto_reg) begin
      frame_next = '0; // see [RULE13]
      playing_next = 1'b1;
    end else if (mode != MODE_AUTO_PLAY) begin
      playing_next = 1'b0;
    end else if (playing_reg && frame_tick && soft_sleep_ctl && !hw_off) begin
      if (frame_reg == LAST_FRAME) begin // see [RULE6] see [RULE13]
        playing_next = 1'b0;
        end_evt = 1'b1; // see [RULE2]
      end else begin
        frame_next = frame_reg + 1'b1;
      end
    end
  end

  // Flag: set on end, cleared only by a read; set wins the tie
  always_comb begin
    flag_next = flag_reg;
    if (req.rd && !hw_off && req.addr == FRAME_STATE_OFS) begin
      flag_next = 1'b0; // see [RULE4]
    end
    if (end_evt) begin
      flag_next = 1'b1; // see [RULE2]
    end
  end

  // Breathing only in picture and auto play, and only when enabled
  always_comb begin
    breath_next = breath_two_reg[BREATH_EN_BIT] && // see [RULE1]
      (mode == MODE_PICTURE || mode == MODE_AUTO_PLAY); // see [RULE14]
    blank_next = hw_off || !soft_sleep_ctl; // see [RULE9] see [RULE11]
  end

  // Pin drive timing; the pin goes low on the same edge the flag sets
  irq_pulse #(
    .LOW_CYCLES(IRQ_LOW)
  ) u_irq_pulse (
    .clk(clk),
    .reset_n(reset_n),
    .start(end_evt),
    .pin_low(pin_low)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= CONFIG_RST;
      breath_two_reg <= BREATH_TWO_RST;
      power_down_reg <= POWER_DOWN_RST;
      flag_reg <= 1'b0;
      frame_reg <= '0;
      playing_reg <= 1'b0;
      prev_auto_reg <= 1'b0;
      rsp_reg <= '0;
      breath_reg <= 1'b0;
      blank_reg <= 1'b1;
    end else begin
      config_reg <= config_next;
      breath_two_reg <= breath_two_next;
      power_down_reg <= power_down_next;
      flag_reg <= flag_next;
      frame_reg <= frame_next;
      playing_reg <= playing_next;
      prev_auto_reg <= prev_auto_next;
      rsp_reg <= rsp_next;
      breath_reg <= breath_next;
      blank_reg <= blank_next;
    end
  end

  assign irq_oe_reg = pin_low; // Pulse module output is a flip-flop
  assign frame_end_irq_n_o = 1'b0; // Open drain: only ever pulls low
  assign frame_end_irq_n_oe = irq_oe_reg; // see [RULE3]
  assign rsp = rsp_reg;
  assign frame_shown = frame_reg;
  assign breath_active = breath_reg;
  assign matrix_blank = blank_reg;
endmodule // matrix_ctl

// *** logic/matrix_ctl_pkg.sv ***
// Package for the matrix LED driver control block: register map,
// field positions, reset values, mode codes, timing and carrier structs.
// Assumes a register access port driven by the serial bus front end.
package matrix_ctl_pkg;
  // Register offsets (function register page)
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] FRAME_STATE_OFS = 8'h07;
  localparam logic [7:0] BREATH_CONTROL_TWO_OFS = 8'h09;
  localparam logic [7:0] POWER_DOWN_CONTROL_OFS = 8'h0a;
  // Field positions
  localparam int MODE_LSB = 3;
  localparam int BREATH_EN_BIT = 4;
  localparam int SOFT_SLEEP_BIT = 0;
  localparam int FRAME_END_BIT = 4;
  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] BREATH_TWO_RST = 8'h00;
  localparam logic [7:0] POWER_DOWN_RST = 8'h00;
  // Frame store
  localparam int FRAME_COUNT = 8;
  localparam int FRAME_IDX_W = 3;
  localparam logic [2:0] LAST_FRAME = 3'h7;
  // Mode codes
  typedef enum logic [1:0] {
    MODE_PICTURE = 2'b00,
    MODE_AUTO_PLAY = 2'b01,
    MODE_AUDIO_A = 2'b10,
    MODE_AUDIO_B = 2'b11
  } play_mode_t;
  // Pin low time
  localparam int IRQ_LOW_MS = 7;
  localparam int CLK_MHZ = 100;
  localparam int IRQ_LOW_CYCLES = IRQ_LOW_MS * 1000 * CLK_MHZ;
  localparam int IRQ_CNT_W = 20;
  // Register access request from the bus front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  // Register read answer
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } reg_rsp_t;
endpackage

// *** logic/irq_pulse.sv ***
// Low pulse generator for the open-drain frame-end interrupt pin.
// Assumes a one-cycle start pulse on the same clock.
`timescale 1ns/100ps
module irq_pulse #(
  parameter int LOW_CYCLES = matrix_ctl_pkg::IRQ_LOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  // Pin drive
  output logic pin_low
);
  import matrix_ctl_pkg::*;
  localparam logic [IRQ_CNT_W-1:0] LAST = IRQ_CNT_W'(LOW_CYCLES - 1);
  logic low_reg, low_next;
  logic [IRQ_CNT_W-1:0] cnt_reg, cnt_next;

  // Hold low for the full count, then let go regardless of the flag
  always_comb begin
    low_next = low_reg;
    cnt_next = cnt_reg;
    if (start) begin
      low_next = 1'b1;
      cnt_next = '0;
    end else if (low_reg) begin
      if (cnt_reg == LAST) begin // see [RULE3] see [RULE15]
        low_next = 1'b0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      low_reg <= low_next;
      cnt_reg <= cnt_next;
    end
  end

  assign pin_low = low_reg;
endmodule // irq_pulse

// *** testbench/matrix_ctl_assertions.sv ***
// Port checker for the matrix control block.
// Assumes the bench keeps requests and frame ticks in separate cycles.
`timescale 1ns/100ps
module matrix_ctl_assertions #(
  parameter int IRQ_LOW = 8
) (
  // Clock, reset, bus
  input wire logic clk,
  input wire logic reset_n,
  input matrix_ctl_pkg::reg_req_t req,
  input matrix_ctl_pkg::reg_rsp_t rsp,
  // Pins and display side
  input wire logic hw_sleep_n,
  input wire logic frame_end_irq_n_o,
  input wire logic frame_end_irq_n_oe,
  input wire logic frame_tick,
  input wire logic [matrix_ctl_pkg::FRAME_IDX_W-1:0] frame_shown,
  input wire logic breath_active,
  input wire logic matrix_blank
);
  import matrix_ctl_pkg::*;
  int low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles the pin has been pulled low so far
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) low_cnt <= 0;
    else low_cnt <= frame_end_irq_n_oe ? low_cnt + 1 : 0;
  end
  sequence s_rd07;
    req.rd && req.addr == FRAME_STATE_OFS && !frame_tick;
  endsequence
  sequence s_pin_up;
    hw_sleep_n [*4];
  endsequence
  property p_od; frame_end_irq_n_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin data high");
  property p_start;
    $rose(frame_end_irq_n_oe) |->
      $past(frame_tick) && $past(frame_shown) == LAST_FRAME;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_len;
    $fell(frame_end_irq_n_oe) |-> low_cnt == IRQ_LOW;
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_blank; !hw_sleep_n [*4] |-> matrix_blank; endproperty
  a_blank: assert property (p_blank) else $error("not blanked");
  property p_refuse; !hw_sleep_n [*4] ##0 req.rd |=> !rsp.valid; endproperty
  a_refuse: assert property (p_refuse) else $error("served");
  property p_serve; s_pin_up ##0 req.rd |=> rsp.valid; endproperty
  a_serve: assert property (p_serve) else $error("read lost");
  // Second read of the state register, two cycles on, sees the flag cleared
  property p_clear;
    s_pin_up ##0 s_rd07 ##1 !frame_tick ##1 s_rd07
      |=> !rsp.rdata[FRAME_END_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  property p_step;
    $changed(frame_shown) && !$past(req.wr) && !$past(req.wr, 2) |->
      $past(frame_tick) && frame_shown == $past(frame_shown) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
endmodule // matrix_ctl_assertions
bind matrix_ctl matrix_ctl_assertions #(.IRQ_LOW(IRQ_LOW)) chk (
  .clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp),
  .hw_sleep_n(hw_sleep_n), .frame_end_irq_n_o(frame_end_irq_n_o),
  .frame_end_irq_n_oe(frame_end_irq_n_oe), .frame_tick(frame_tick),
  .frame_shown(frame_shown), .breath_active(breath_active),
  .matrix_blank(matrix_blank));

// *** testbench/host_model.sv ***
// Host model: register requests, shutdown pin and frame ticks.
// Assumes one-cycle requests taken on the rising edge of clk.
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk,
  // Bus and pins
  output matrix_ctl_pkg::reg_req_t req,
  input matrix_ctl_pkg::reg_rsp_t rsp,
  output logic hw_sleep_n,
  output logic frame_tick
);
  import matrix_ctl_pkg::*;
  // Idle bus shows inverted leftovers so stale values never look valid
  initial begin
    req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
    hw_sleep_n = 1'b1;
    frame_tick = 1'b0;
  end
  task automatic access(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Whole bytes only; frame data for unused spots is kept outside
  task automatic wr(input logic [7:0] a, d);
    access(1'b1, a, d);
  endtask
  // The answer stands only in the cycle after the request edge: take it
  // there, before the next edge clears it
  task automatic rd(input logic [7:0] a, output reg_rsp_t r);
    access(1'b0, a, 8'h00);
    r = rsp;
  endtask
  // Shutdown pin changes on the falling edge, like every other input
  task automatic sleep_pin(input logic v);
    @(negedge clk);
    hw_sleep_n = v;
  endtask
  task automatic tick();
    @(negedge clk);
    frame_tick = 1'b1;
    @(negedge clk);
    frame_tick = 1'b0;
  endtask
endmodule // host_model

// *** testbench/matrix_ctl_tb.sv ***
// Self-checking bench for the matrix control block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
module matrix_ctl_tb;
  import matrix_ctl_pkg::*;
  localparam int LOW = 8;
  logic clk;
  logic reset_n;
  reg_req_t req;
  reg_rsp_t rsp;
  reg_rsp_t r;
  logic hw_sleep_n, frame_tick, irq_o, irq_oe, breath, blank;
  logic [2:0] shown;
  logic [7:0] ofs [5] = '{8'h00, 8'h07, 8'h09, 8'h0a, 8'h05};
  int fails = 0;
  int tests_run = 0;
  matrix_ctl #(.IRQ_LOW(LOW)) DUT (.clk(clk), .reset_n(reset_n),
    .req(req), .rsp(rsp), .hw_sleep_n(hw_sleep_n),
    .frame_end_irq_n_o(irq_o), .frame_end_irq_n_oe(irq_oe),
    .frame_tick(frame_tick), .frame_shown(shown),
    .breath_active(breath), .matrix_blank(blank));
  host_model h (.clk(clk), .req(req), .rsp(rsp),
    .hw_sleep_n(hw_sleep_n), .frame_tick(frame_tick));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string n, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results();
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well past the hundred or so cycles the tests need
  initial begin
    #20us;
    fails++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // Reset values, unmapped place reads as zero
    foreach (ofs[i]) begin
      h.rd(ofs[i], r);
      check("reset value", {r.rdata[6:0], r.valid}, 8'h01);
    end
    check("blank", {7'h0, blank}, 8'h01);
    check("pin data", {7'h0, irq_o}, 8'h00);
    h.wr(POWER_DOWN_CONTROL_OFS, 8'h01);
    h.wr(BREATH_CONTROL_TWO_OFS, 8'h10);
    // Every mode code; breathing only for picture and auto play
    for (int m = 0; m < 4; m++) begin
      h.wr(CONFIG_OFS, 8'(m << 3));
      repeat (2) @(negedge clk);
      check("breath", {7'h0, breath}, {7'h0, m < 2});
    end
    check("blank", {7'h0, blank}, 8'h00);
    h.wr(BREATH_CONTROL_TWO_OFS, 8'h00);
    h.wr(CONFIG_OFS, 8'h00);
    repeat (2) @(negedge clk);
    check("breath", {7'h0, breath}, 8'h00);
    // Auto play through all eight frames, then the pin pulse
    h.wr(CONFIG_OFS, 8'h08);
    repeat (2) @(negedge clk);
    for (int i = 0; i < FRAME_COUNT; i++) begin
      check("frame", {5'h0, shown}, 8'(i));
      h.tick();
    end
    check("pin low", {7'h0, irq_oe}, 8'h01);
    // Pin must stay pulled for the whole low time, then let go
    repeat (LOW - 1) @(negedge clk);
    check("pin held", {7'h0, irq_oe}, 8'h01);
    repeat (3) @(negedge clk);
    check("pin back", {7'h0, irq_oe}, 8'h00);
    h.rd(FRAME_STATE_OFS, r);
    check("flag", r.rdata & 8'h10, 8'h10);
    h.rd(FRAME_STATE_OFS, r);
    check("flag read", r.rdata & 8'h10, 8'h00);
    // Soft shutdown blanks but keeps serving the bus
    h.wr(POWER_DOWN_CONTROL_OFS, 8'h00);
    h.wr(BREATH_CONTROL_TWO_OFS, 8'h10);
    h.rd(BREATH_CONTROL_TWO_OFS, r);
    check("soft read", r.rdata, 8'h10);
    check("blank", {7'h0, blank}, 8'h01);
    h.wr(POWER_DOWN_CONTROL_OFS, 8'h01);
    // Pin shutdown refuses access and keeps contents
    h.sleep_pin(1'b0);
    repeat (4) @(negedge clk);
    check("pin blank", {7'h0, blank}, 8'h01);
    h.wr(BREATH_CONTROL_TWO_OFS, 8'h00);
    h.rd(BREATH_CONTROL_TWO_OFS, r);
    check("refused", {7'h0, r.valid}, 8'h00);
    h.sleep_pin(1'b1);
    repeat (4) @(negedge clk);
    h.rd(BREATH_CONTROL_TWO_OFS, r);
    check("kept", r.rdata, 8'h10);
    check("awake", {7'h0, blank}, 8'h00);
    results();
  end
endmodule // matrix_ctl_tb
